//--- rtl/cwd_consts.vh
/*
 Constants for the configuration word decoder: word address, test space
 bounds, field positions, oscillator codes and start-up timing counts.
 Assumes a 250 MHz core clock; included by bare name.
*/
`ifndef CWD_CONSTS_VH
`define CWD_CONSTS_VH

// Configuration space
`define CWD_CFG_ADDR        14'h2007
`define CWD_TEST_LO         14'h2000
`define CWD_TEST_HI         14'h3FFF
`define CWD_WORD_W          14
`define CWD_ERASED          14'h3FFF

// Field positions
`define CWD_OSC_LO_BIT      0
`define CWD_OSC_HI_BIT      1
`define CWD_WDT_BIT         2
`define CWD_PUD_BIT         3
`define CWD_CP_LO_A         4
`define CWD_CP_LO_B         5
`define CWD_BOD_BIT         6
`define CWD_CP_HI_LSB       7
`define CWD_CP_HI_MSB       13

// Oscillator select codes
`define CWD_OSC_LP          2'h0
`define CWD_OSC_XT          2'h1
`define CWD_OSC_HS          2'h2
`define CWD_OSC_RC          2'h3

// Unprotected window of program memory
`define CWD_OPEN_LO         11'h000
`define CWD_OPEN_HI         11'h03F

// Timing
`define CWD_CLK_MHZ         250
`define CWD_PUD_MS          72
`define CWD_PUD_CYCLES      (`CWD_PUD_MS * 1000 * `CWD_CLK_MHZ)
`define CWD_SETTLE_EDGES    1024
`define CWD_SETTLE_LAST     11'h3FF

`endif

//--- rtl/cwd_clkout_div.v
/*
 Divide-by-four of the sampled oscillator input for the clock-output pin.
 Assumes the oscillator input is a synchronous sample of the pin.
*/
`timescale 1ns/1ns
module cwd_clkout_div (
    input  wire        clock,
    input  wire        reset_n,
    input  wire        oscRise,
    output reg         clkOut
);
    reg [0:0] halfCount;

    // Toggle every second rising edge gives osc/4
    always @(posedge clock) begin
        if (!reset_n) begin
            halfCount <= 1'h0;
            clkOut    <= 1'h0;
        end else if (oscRise) begin
            halfCount <= halfCount + 1'h1;
            if (halfCount == 1'h1)
                clkOut <= ~clkOut;
        end
    end
endmodule // cwd_clkout_div

//--- rtl/cwd_edge_counter.v
/*
 Counter of oscillator input rising edges for the settle timer.
 Assumes start is held high while counting is wanted.
*/
`timescale 1ns/1ns
`include "cwd_consts.vh"
module cwd_edge_counter (
    input  wire        clock,
    input  wire        reset_n,
    input  wire        start,
    input  wire        oscRise,
    output reg         done
);
    reg [10:0] edgeCount;

    // Counts edges while started; restarts whenever start drops
    always @(posedge clock) begin
        if (!reset_n || !start) begin
            edgeCount <= 11'h000;
            done      <= 1'h0;
        end else if (!done && oscRise) begin
            edgeCount <= edgeCount + 11'h001;
            if (edgeCount == `CWD_SETTLE_LAST) // Last of the settle edges
                done <= 1'h1;
        end
    end
endmodule // cwd_edge_counter

//--- rtl/cwd_config_decoder.v
/*
 Configuration word decoder with power-up and oscillator settle timers,
 sleep wake logic and clock-output divider.
 Assumes a programmer writes the word only while progMode is high, and
 that powerOnReset is a one-cycle pulse after supply rise.
*/
`timescale 1ns/1ns
`include "cwd_consts.vh"
module cwd_config_decoder #(
    parameter [31:0] PUD_CYCLES = `CWD_PUD_CYCLES
) (
    input  wire        clock,
    input  wire        reset_n,
    input  wire        progMode,
    input  wire        progWrite,
    input  wire [13:0] progAddr,
    input  wire [13:0] progData,
    input  wire        progRead,
    input  wire        powerOnReset,
    input  wire        externalReset,
    input  wire        sleepRequest,
    input  wire        watchdogWake,
    input  wire        interruptWake,
    input  wire        oscillatorInput,
    input  wire        userAccess,
    input  wire        userWrite,
    input  wire [10:0] userAddr,
    output reg  [13:0] progReadData,
    output reg         progAccessOk,
    output reg  [1:0]  oscMode,
    output reg         watchdogEnable,
    output reg         powerupDelayActive,
    output reg         brownoutDetectEnable,
    output reg         codeProtect,
    output reg         codeProtectMixed,
    output reg         userWriteAllowed,
    output reg         deviceInReset,
    output reg         sleeping,
    output reg         oscillatorOutputPin
);
    localparam [1:0] ST_POWERUP = 2'h0;
    localparam [1:0] ST_SETTLE  = 2'h1;
    localparam [1:0] ST_RUN     = 2'h2;
    localparam [1:0] ST_SLEEP   = 2'h3;

    reg  [13:0] cfgWord;
    reg  [13:0] liveWord;
    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg  [31:0] pudCount;
    reg         oscSample;
    reg         settleStart;
    wire        oscRise;
    wire        settleDone;
    wire        clkDiv;
    wire        cfgHit;
    wire        testHit;
    wire        inTestSpace;
    wire [8:0]  cpBits;
    wire        cpAllOne;
    wire        cpAllZero;
    wire        xtalMode;
    wire        pudEnable;

    // Address decode of the test space
    assign inTestSpace = (progAddr >= `CWD_TEST_LO) && (progAddr <= `CWD_TEST_HI);
    assign testHit     = progMode && inTestSpace;
    assign cfgHit      = testHit && (progAddr == `CWD_CFG_ADDR);

    // Replicated protect bits; disagreement is flagged, not trusted
    // Taken from the latched word so protection stays static in run
    assign cpBits    = {cfgWord[`CWD_CP_HI_MSB:`CWD_CP_HI_LSB], cfgWord[`CWD_CP_LO_B],
                        cfgWord[`CWD_CP_LO_A]};
    assign cpAllOne  = &cpBits;
    assign cpAllZero = ~|cpBits;

    // Crystal modes accept crystal or external clock alike
    assign xtalMode  = (liveWord[1:0] != `CWD_OSC_RC);
    assign pudEnable = ~liveWord[`CWD_PUD_BIT] | liveWord[`CWD_BOD_BIT];

    // Oscillator input edge detect; pin is sampled synchronously
    assign oscRise = oscillatorInput & ~oscSample;

    // Programmer storage: erased word until written
    always @(posedge clock) begin
        if (!reset_n) begin
            liveWord <= `CWD_ERASED;
        end else if (progWrite && cfgHit) begin
            liveWord <= progData;
        end
    end

    // Read-back only in programming mode; other test-space addresses read erased, lower addresses read zero
    always @(posedge clock) begin
        if (!reset_n) begin
            progReadData <= 14'h0000;
            progAccessOk <= 1'h0;
        end else begin
            progAccessOk <= testHit && (progRead || progWrite);
            if (progRead && cfgHit)
                progReadData <= liveWord;
            else if (progRead && testHit)
                progReadData <= `CWD_ERASED;
            else
                progReadData <= 14'h0000;
        end
    end

    // Start-up sequencer: power-up delay, settle, run, sleep
    always @* begin
        next_state = state;
        case (state)
            ST_POWERUP: begin
                if (!pudEnable || pudCount >= PUD_CYCLES - 32'h1)
                    next_state = xtalMode ? ST_SETTLE : ST_RUN;
            end
            ST_SETTLE: begin
                if (settleDone)
                    next_state = ST_RUN;
            end
            ST_RUN: begin
                if (sleepRequest)
                    next_state = ST_SLEEP;
            end
            ST_SLEEP: begin
                if (watchdogWake || interruptWake)
                    next_state = xtalMode ? ST_SETTLE : ST_RUN;
            end
            default: next_state = ST_POWERUP;
        endcase
    end

    // Power-on restarts the delay; external reset skips it
    always @(posedge clock) begin
        if (!reset_n || powerOnReset) begin
            state    <= ST_POWERUP;
            pudCount <= 32'h0;
        end else if (externalReset) begin
            state    <= ST_RUN;
            pudCount <= 32'h0;
        end else begin
            state    <= next_state;
            pudCount <= (state == ST_POWERUP) ? pudCount + 32'h1 : 32'h0;
        end
    end

    // Word latched only in the power-up state or on an external reset, so controls stay static
    always @(posedge clock) begin
        if (!reset_n) begin
            cfgWord <= `CWD_ERASED;
        end else if (state == ST_POWERUP || externalReset) begin
            cfgWord <= liveWord;
        end
    end

    // Decoded controls; no software path reaches the watchdog enable
    always @(posedge clock) begin
        if (!reset_n) begin
            oscMode              <= `CWD_OSC_RC;
            watchdogEnable       <= 1'h1;
            powerupDelayActive   <= 1'h0;
            brownoutDetectEnable <= 1'h1;
            codeProtect          <= 1'h0;
            codeProtectMixed     <= 1'h0;
            userWriteAllowed     <= 1'h0;
            deviceInReset        <= 1'h1;
            sleeping             <= 1'h0;
            oscSample            <= 1'h0;
            settleStart          <= 1'h0;
        end else begin
            oscMode              <= cfgWord[`CWD_OSC_HI_BIT:`CWD_OSC_LO_BIT];
            watchdogEnable       <= cfgWord[`CWD_WDT_BIT];
            powerupDelayActive   <= (state == ST_POWERUP) && pudEnable;
            brownoutDetectEnable <= cfgWord[`CWD_BOD_BIT];
            codeProtect          <= ~cpAllOne;
            codeProtectMixed     <= ~cpAllOne && ~cpAllZero;
            userWriteAllowed     <= userAccess && userWrite && !progMode
                                    && (cpAllOne || userAddr <= `CWD_OPEN_HI);
            // Restart pulses override the sequencer's next state
            deviceInReset        <= powerOnReset || (!externalReset &&
                                    ((next_state == ST_POWERUP) || (next_state == ST_SETTLE)));
            sleeping             <= !powerOnReset && !externalReset && (next_state == ST_SLEEP);
            oscSample            <= oscillatorInput;
            settleStart          <= !powerOnReset && !externalReset
                                    && (next_state == ST_SETTLE);
        end
    end

    // Clock-output pin carries osc/4 only in RC mode
    always @(posedge clock) begin
        if (!reset_n)
            oscillatorOutputPin <= 1'h0;
        else
            oscillatorOutputPin <= (cfgWord[1:0] == `CWD_OSC_RC) ? clkDiv : 1'h0;
    end

    cwd_edge_counter u_settle (
        .clock   (clock),
        .reset_n (reset_n),
        .start   (settleStart),
        .oscRise (oscRise),
        .done    (settleDone)
    );

    cwd_clkout_div u_div (
        .clock   (clock),
        .reset_n (reset_n),
        .oscRise (oscRise),
        .clkOut  (clkDiv)
    );
endmodule // cwd_config_decoder

//--- testbench/cwd_programmer.sv
/* Programmer model for the configuration port.
   Assumes the bench calls its task; lines change at falling edges. */
`timescale 1ns/1ns
module cwd_programmer (
    input  wire        clock,
    output reg         progMode,
    output reg         progWrite,
    output reg         progRead,
    output reg  [13:0] progAddr,
    output reg  [13:0] progData
);
    initial {progMode, progWrite, progRead, progAddr, progData} = 31'h0;
    // One strobe; idle lines scrambled so stale values never look valid
    task access(input m, input wr, input [13:0] a, input [13:0] d);
        begin
            @(negedge clock);
            {progMode, progWrite, progRead} = {m, wr, !wr};
            {progAddr, progData} = {a, d};
            @(negedge clock);
            {progMode, progWrite, progRead} = 3'h0;
            {progAddr, progData} = {~a, ~d};
        end
    endtask
    // Same value into every protect bit, bit 4 included
    function [13:0] word(input [1:0] osc, input wdt, input pudN, input bod, input cp);
        word = {{7{cp}}, bod, cp, cp, pudN, wdt, osc};
    endfunction
endmodule // cwd_programmer

//--- testbench/cwd_checker.sv
/* Checker on the decoder ports.
   Bound to the decoder; takes its delay parameter. */
`timescale 1ns/1ns
`include "cwd_consts.vh"
module cwd_checker #(parameter [31:0] PUD_CYCLES = 20) (
    input logic        clock,
    input logic        reset_n,
    input logic        progMode,
    input logic        progWrite,
    input logic        progRead,
    input logic [13:0] progAddr,
    input logic [13:0] progReadData,
    input logic        progAccessOk,
    input logic        powerOnReset,
    input logic        externalReset,
    input logic [1:0]  oscMode,
    input logic        watchdogEnable,
    input logic        brownoutDetectEnable,
    input logic        codeProtect,
    input logic        codeProtectMixed,
    input logic        powerupDelayActive,
    input logic        deviceInReset,
    input logic        oscillatorOutputPin
);
    logic [31:0] pudCount;
    logic [2:0]  recent;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Length of the running delay
    always @(posedge clock)
        pudCount <= (!reset_n || powerOnReset || !powerupDelayActive) ? 32'h0
                    : pudCount + 32'h1;
    // Short window after a restart where controls may move
    always @(posedge clock)
        recent <= (!reset_n || powerOnReset || externalReset || deviceInReset) ? 3'h4
                  : recent - {2'h0, recent != 3'h0};
    sequence s_settle_start;
        $fell(powerupDelayActive) && oscMode != `CWD_OSC_RC;
    endsequence
    a_refuse_idle: assert property (
        (progWrite || progRead) && !progMode |=> !progAccessOk) else $error("ack w/o mode");
    a_take_test: assert property (
        (progWrite || progRead) && progMode && progAddr[13] |=> progAccessOk)
        else $error("test access not acked");
    a_read_outside: assert property (
        progRead && !progAddr[13] |=> progReadData == 14'h0000) else $error("user read data");
    a_word_static: assert property (
        $changed({oscMode, watchdogEnable, brownoutDetectEnable, codeProtect}) |-> recent != 3'h0)
        else $error("control moved in run");
    a_pud_length: assert property (
        $fell(powerupDelayActive) |-> pudCount >= PUD_CYCLES && pudCount <= PUD_CYCLES + 1)
        else $error("delay length");
    a_settle_hold: assert property (
        s_settle_start |-> deviceInReset [*8]) else $error("no settle wait");
    a_mixed_flag: assert property (
        codeProtectMixed |-> codeProtect) else $error("mixed w/o protect");
    a_clkout_idle: assert property (
        oscMode != `CWD_OSC_RC && $past(oscMode) != `CWD_OSC_RC |-> !oscillatorOutputPin)
        else $error("clock out in crystal mode");
endmodule // cwd_checker

//--- testbench/cwd_config_decoder_test.sv
/* Self-checking bench for the decoder.
   Assumes the programmer model and the checker. */
`timescale 1ns/1ns
module cwd_config_decoder_test;
    localparam P = 20;
    reg         clock, reset_n, powerOnReset, externalReset, sleepRequest;
    reg         watchdogWake, interruptWake, oscillatorInput, userAccess, userWrite;
    reg  [10:0] userAddr;
    wire        progMode, progWrite, progRead, progAccessOk, watchdogEnable, sleeping;
    wire        powerupDelayActive, brownoutDetectEnable, codeProtect, codeProtectMixed;
    wire        userWriteAllowed, deviceInReset, oscillatorOutputPin;
    wire [13:0] progAddr, progData, progReadData;
    wire [1:0]  oscMode;
    integer     seed, miscompares, check_count, i, n, w, x, cpE, rises, q[$];
    cwd_programmer i_prog (.clock, .progMode, .progWrite, .progRead, .progAddr, .progData);
    cwd_config_decoder #(.PUD_CYCLES(P)) i_dut (.clock, .reset_n, .progMode, .progWrite,
        .progAddr, .progData, .progRead, .powerOnReset, .externalReset, .sleepRequest,
        .watchdogWake, .interruptWake, .oscillatorInput, .userAccess, .userWrite, .userAddr,
        .progReadData, .progAccessOk, .oscMode, .watchdogEnable, .powerupDelayActive,
        .brownoutDetectEnable, .codeProtect, .codeProtectMixed, .userWriteAllowed,
        .deviceInReset, .sleeping, .oscillatorOutputPin);
    // Clock, and a crystal at a quarter of its rate
    initial begin
        clock = 0;
        forever #2 clock = ~clock;
    end
    always #8 oscillatorInput = ~oscillatorInput;
    always @(posedge oscillatorOutputPin) rises = rises + 1;
    initial begin
        #200000 miscompares = miscompares + 1;
        end_of_test;
    end
    task chk(input integer e, input [15:0] g, input [63:0] nm);
        begin
            check_count = check_count + 1;
            if (e !== g) begin
                miscompares = miscompares + 1;
                $display("ERROR %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // Expected controls from the word in w
    task model;
        begin
            cpE = (w >> 7 & 127) != 127 || (w >> 4 & 3) != 3;
            chk(w & 3, oscMode, "mode");
            chk(w >> 2 & 1, watchdogEnable, "wdt");
            chk(w >> 6 & 1, brownoutDetectEnable, "bod");
            chk(cpE, codeProtect, "cp");
            chk(cpE && ((w >> 7 & 127) != 0 || (w >> 4 & 3) != 0), codeProtectMixed, "mixed");
        end
    endtask
    // Restart pulse; n counts cycles until run
    task kick(input ext);
        begin
            @(negedge clock) {powerOnReset, externalReset} = {!ext, ext};
            @(negedge clock) {powerOnReset, externalReset} = 2'h0;
            for (n = 1; deviceInReset !== 1'b0 && n < 9000; n = n + 1) @(negedge clock);
            repeat (3) @(negedge clock);
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d miscompares %0d", check_count, miscompares);
            if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        {reset_n, powerOnReset, externalReset, sleepRequest, watchdogWake} = 5'h00;
        {interruptWake, oscillatorInput, userAccess, userWrite, userAddr} = 15'h0000;
        {seed, miscompares, check_count, rises} = {32'h6D7A, 96'h0};
        q = {14'h3FFF};
        repeat (12) @(negedge clock);
        reset_n = 1;
        // Erased word defaults, refused and spare accesses
        kick(0);
        w = q[0];
        model;
        for (i = 0; i < 3; i = i + 1) begin
            i_prog.access(i != 0, 0, i == 0 ? 14'h2007 : i == 1 ? 14'h1FFF : 14'h3FFF, 0);
            chk(i == 2, progAccessOk, "ack");
            if (i != 0) chk(i == 2 ? 14'h3FFF : 0, progReadData, "rdata");
        end
        $display("test 1 done");
        // New word held until restart; user write queries
        for (i = 0; i < 8; i = i + 1) begin
            x = $random(seed);
            // Bit 7 flipped now and then to break the uniform setting
            q.push_back(i_prog.word(i, x[0], x[1], x[2], x[3]) ^ (x[4] << 7));
            i_prog.access(1, 1, 14'h2007, q[1]);
            chk(1, progAccessOk, "ack");
            i_prog.access(1, 0, 14'h2007, 0);
            chk(q[1], progReadData, "rdata");
            w = q.pop_front();
            model;
            kick(1);
            w = q[0];
            model;
            @(negedge clock);
            {userAccess, userWrite, userAddr} = {2'h3, x[15:11] & {5{x[16]}}, x[10:5]};
            @(negedge clock) {userAccess, userWrite} = 2'h0;
            chk(!cpE || userAddr < 64, userWriteAllowed, "uwr");
        end
        $display("test 2 done");
        // Start-up time for XT, HS and RC oscillators and each delay setting
        for (i = 0; i < 4; i = i + 1) begin
            w = i_prog.word(i == 1 ? 1 : i == 2 ? 2 : 3, 1, i != 0, i == 1, 1);
            i_prog.access(1, 1, 14'h2007, w);
            kick(0);
            x = ((!(w >> 3 & 1) || (w >> 6 & 1)) ? P : 0) + ((w & 3) != 3 ? 1024 * 4 : 0);
            chk(1, n >= x - 4 && n <= x + 8, "startup");
            rises = 0;
            repeat (160) @(negedge clock);
            chk((w & 3) == 3 ? 10 : 0, rises, "clkout");
        end
        $display("test 3 done");
        // Every wake source ends sleep
        for (i = 0; i < 3; i = i + 1) begin
            @(negedge clock) sleepRequest = 1;
            @(negedge clock) sleepRequest = 0;
            @(negedge clock) chk(1, sleeping, "sleep");
            {watchdogWake, interruptWake, externalReset} = 3'h1 << i;
            @(negedge clock) {watchdogWake, interruptWake, externalReset} = 3'h0;
            for (n = 0; sleeping !== 1'b0 && n < 50; n = n + 1) @(negedge clock);
            chk(0, sleeping, "wake");
            chk(1, watchdogEnable, "wdt");
        end
        $display("test 4 done");
        end_of_test;
    end
endmodule // cwd_config_decoder_test
bind cwd_config_decoder cwd_checker #(.PUD_CYCLES(PUD_CYCLES)) i_chk (.clock, .reset_n,
    .progMode, .progWrite, .progRead, .progAddr, .progReadData, .progAccessOk,
    .powerOnReset, .externalReset, .oscMode, .watchdogEnable, .brownoutDetectEnable,
    .codeProtect, .codeProtectMixed, .powerupDelayActive, .deviceInReset,
    .oscillatorOutputPin);
